// >>> logic/osy_defs.vh
// Purpose: Constants for the output divider synchronization block.
// Assumes: Byte-wide registers on a 16-bit address port.
// Notes:   Definitions only; included by every design file except the two-flop synchronizer.
`ifndef OSY_DEFS_VH
`define OSY_DEFS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define OSY_ADDR_CL_PHASE  16'h030f
`define OSY_ADDR_SLEW      16'h0316
`define OSY_ADDR_SYNC_CTRL 16'h0402
`define OSY_ADDR_AUTO_SYNC 16'h0403
`define OSY_ADDR_MF_SEL    16'h0410
`define OSY_ADDR_DIV_BASE  16'h0420
`define OSY_ADDR_SW_SYNC   16'h0a02
`define OSY_ADDR_STATUS    16'h0d03

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define OSY_SW_SYNC_BIT    1
`define OSY_SRC_MSB        5
`define OSY_SRC_LSB        4
`define OSY_MASK_MSB       3
`define OSY_SRC_DIRECT     2'h0
`define OSY_SRC_ACT_REF    2'h1
`define OSY_SRC_FEEDBACK   2'h2
`define OSY_AUTO_FREQ      2'h1
`define OSY_AUTO_PHASE     2'h2
`define OSY_MF_EN_BIT      3
`define OSY_STAT_ARMED_BIT 0
`define OSY_STAT_PEND_BIT  3
`define OSY_DIV_WIDTH      30

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define OSY_RST_BYTE       8'h00
`define OSY_RECLOCK_CYCLES 3'h4

`endif

// >>> logic/osy_sync2.v
// Purpose: Two-flop synchronizer for a bus of independent levels.
// Assumes: Each bit is an unrelated asynchronous level.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none

module osy_sync2 #(
  parameter W = 8
) (
  input  wire         clock,
  input  wire         rst_n,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // osy_sync2

`default_nettype wire

// >>> logic/osy_chan_div.v
// Purpose: One output channel divider with stall and restart.
// Assumes: ratio_m1 is the programmed value; division is ratio_m1 + 1.
// Notes:   A ratio of one cannot be made from flops; the output then stays low.
`timescale 1ns/100ps
`default_nettype none
`include "osy_defs.vh"

module osy_chan_div (
  input  wire                       clock,
  input  wire                       rst_n,
  input  wire [`OSY_DIV_WIDTH-1:0]  ratio_m1,
  input  wire                       stall,
  input  wire                       restart,
  output wire                       clk_out
);

  reg  [`OSY_DIV_WIDTH-1:0] cnt_q;
  reg                       out_q;
  reg                       hold_q;
  wire [`OSY_DIV_WIDTH:0]   half;
  wire                      wrap;

  assign half = ({1'b0, ratio_m1} + {{`OSY_DIV_WIDTH{1'b0}}, 1'b1}) >> 1;
  assign wrap = (cnt_q == ratio_m1);

  // A restarted divider keeps its output low for one full output period,
  // so the first edge lands one divider period after the restart.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= {`OSY_DIV_WIDTH{1'b0}};
      out_q  <= 1'b0;
      hold_q <= 1'b0;
    end else if (stall || restart) begin
      cnt_q  <= {`OSY_DIV_WIDTH{1'b0}};
      out_q  <= 1'b0;
      hold_q <= restart;
    end else begin
      cnt_q  <= wrap ? {`OSY_DIV_WIDTH{1'b0}} : cnt_q + 1'b1;
      if (wrap) begin
        hold_q <= 1'b0;
      end
      out_q  <= !(hold_q && !wrap) && ({1'b0, (wrap ? {`OSY_DIV_WIDTH{1'b0}} :
                cnt_q + 1'b1)} < half);
    end
  end

  assign clk_out = out_q;

endmodule // osy_chan_div

`default_nettype wire

// >>> logic/osy_output_sync.v
// Purpose: Synchronization of the four output clock dividers.
// Assumes: One clock, the distribution clock; lock and feedback inputs are
//          synchronous; pins and reference inputs are not.
// Notes:   Register port with read data one cycle after the read strobe.
//
// Contract
// - Primary sync is OR of four sources.
// - Software bit one-to-zero transition is the event.
// - Multifunction pin falling edge is the event.
// - Mode 00: primary falling edge syncs directly.
// - Mode 01: arm, next reference rising edge syncs.
// - Mode 10: arm, feedback rollover edge syncs.
// - Armed detector stalls unmasked dividers immediately.
// - Reference edge drops detector, restarting dividers.
// - Reference mux follows the active reference.
// - Reclock event; restart after latency plus period.
// - Alignment happens once per event, open-loop.
// - Masked channel ignores the sync entirely.
// - Masked channels run while unmasked stay stalled.
// - Automatic source fires on selected lock detection.
// - Storage memory request is one ORed source.
// - Slew limit bounds closed-loop phase change rate.
// - Channel divides by programmed value plus one.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "osy_defs.vh"

module osy_output_sync (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [15:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [7:0]  reg_rdata,
  input  wire [7:0]  multifunction_pins,
  input  wire [7:0]  ref_in,
  input  wire [2:0]  active_ref_sel,
  input  wire        dpll_freq_lock,
  input  wire        dpll_phase_lock,
  input  wire        eeprom_sync_req,
  input  wire        fb_rollover,
  output wire [3:0]  out_clk,
  output wire        sync_pending,
  output wire [7:0]  phase_applied
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [7:0]  ctrl_q;
  reg  [7:0]  auto_q;
  reg         sw_q;
  reg  [7:0]  mf_sel_q;
  reg  [7:0]  cl_tgt_q;
  reg  [7:0]  slew_q;
  reg  [7:0]  div_q [0:15];
  reg  [7:0]  rdata_q;
  reg  [7:0]  rdata_d;
  reg         lock_prev_q;
  reg         auto_pulse_q;
  reg         prim_q;
  reg         ref_prev_q;
  reg         armed_q;
  reg  [2:0]  rc_q;
  reg         restart_q;
  reg         pend_q;
  reg  [7:0]  phase_q;
  reg  [7:0]  phase_d;
  wire [7:0]  mf_s;
  wire [7:0]  ref_s;
  wire [1:0]  src;
  wire [3:0]  mask;
  wire        lock_sel;
  wire        pin_lvl;
  wire        primary;
  wire        prim_rise;
  wire        prim_fall;
  wire        ref_cur;
  wire        ref_rise;
  wire        arm_mode;
  wire        release_ev;
  wire        direct_hit;
  wire        ref_hit;
  wire        fb_hit;
  wire        stall_int;
  wire        div_hit;
  wire [7:0]  step_up;
  wire [7:0]  step_dn;
  integer     i;

  assign src  = ctrl_q[`OSY_SRC_MSB:`OSY_SRC_LSB];
  assign mask = ctrl_q[`OSY_MASK_MSB:0];

  // ****************************************************************
  // Register writes
  // ****************************************************************
  assign div_hit = (reg_addr[15:4] == `OSY_ADDR_DIV_BASE >> 4);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= `OSY_RST_BYTE;
      auto_q   <= `OSY_RST_BYTE;
      sw_q     <= 1'b0;
      mf_sel_q <= `OSY_RST_BYTE;
      cl_tgt_q <= `OSY_RST_BYTE;
      slew_q   <= `OSY_RST_BYTE;
      for (i = 0; i < 16; i = i + 1) begin
        div_q[i] <= `OSY_RST_BYTE;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `OSY_ADDR_SYNC_CTRL: ctrl_q   <= reg_wdata;
        `OSY_ADDR_AUTO_SYNC: auto_q   <= reg_wdata;
        `OSY_ADDR_SW_SYNC:   sw_q     <= reg_wdata[`OSY_SW_SYNC_BIT];
        `OSY_ADDR_MF_SEL:    mf_sel_q <= reg_wdata;
        `OSY_ADDR_CL_PHASE:  cl_tgt_q <= reg_wdata;
        `OSY_ADDR_SLEW:      slew_q   <= reg_wdata;
        default: begin
          if (div_hit) begin
            div_q[reg_addr[3:0]] <= reg_wdata;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // The top two bits of each divider's last byte lie beyond the
  // 30-bit divider and read as zero.
  // Software reads pending and armed from the status byte to learn that
  // a sync has completed before it moves any edge timing.
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `OSY_ADDR_SYNC_CTRL: rdata_d = {2'h0, ctrl_q[5:0]};
      `OSY_ADDR_AUTO_SYNC: rdata_d = {6'h00, auto_q[1:0]};
      `OSY_ADDR_SW_SYNC:   rdata_d = {6'h00, sw_q, 1'b0};
      `OSY_ADDR_MF_SEL:    rdata_d = {4'h0, mf_sel_q[3:0]};
      `OSY_ADDR_CL_PHASE:  rdata_d = cl_tgt_q;
      `OSY_ADDR_SLEW:      rdata_d = slew_q;
      `OSY_ADDR_STATUS:    rdata_d = {4'h0, pend_q, 2'h0, armed_q};
      default: begin
        if (div_hit) begin
          rdata_d = (reg_addr[1:0] == 2'h3) ? {2'h0, div_q[reg_addr[3:0]][5:0]}
                                             : div_q[reg_addr[3:0]];
        end
      end
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rdata_d : 8'h00;
    end
  end

  // ****************************************************************
  // Trigger sources
  // ****************************************************************
  osy_sync2 #(.W(8)) u_mf_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (multifunction_pins),
    .sync_out (mf_s)
  );

  osy_sync2 #(.W(8)) u_ref_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (ref_in),
    .sync_out (ref_s)
  );

  // The pin contributes its level, so its falling edge is the
  // falling edge of the primary signal.
  assign pin_lvl = mf_sel_q[`OSY_MF_EN_BIT] & mf_s[mf_sel_q[2:0]];

  assign lock_sel = (auto_q[1:0] == `OSY_AUTO_FREQ)  ? dpll_freq_lock :
                    (auto_q[1:0] == `OSY_AUTO_PHASE) ? dpll_phase_lock : 1'b0;

  // Lock detection gives a single pulse on acquisition, so a held lock
  // does not keep the primary signal high forever.
  // Switching the selection from one held lock to another held lock
  // gives no pulse, since the previous level is already high; a held
  // lock counts as an acquisition once it is first selected, as reset
  // leaves the selection at zero.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_prev_q  <= 1'b0;
      auto_pulse_q <= 1'b0;
    end else begin
      lock_prev_q  <= lock_sel;
      auto_pulse_q <= lock_sel & ~lock_prev_q;
    end
  end

  // Software bit level is a source; clearing it gives the falling edge.
  assign primary = sw_q | auto_pulse_q | pin_lvl | eeprom_sync_req;

  // ****************************************************************
  // Edge detection and arming
  // ****************************************************************
  // Moving the selection onto a reference that is already high counts
  // as a rising edge; the mux follows the active reference without any
  // guard against that.
  assign ref_cur  = ref_s[active_ref_sel];
  assign ref_rise = ref_cur & ~ref_prev_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prim_q     <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      prim_q     <= primary;
      ref_prev_q <= ref_cur;
    end
  end

  assign prim_rise = primary & ~prim_q;
  assign prim_fall = ~primary & prim_q;
  assign arm_mode  = (src == `OSY_SRC_ACT_REF) || (src == `OSY_SRC_FEEDBACK);

  // The detector disarms after one awaited edge and waits for a new
  // primary rising edge; later drift is never corrected.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (!arm_mode) begin
      armed_q <= 1'b0;
    end else if (armed_q) begin
      if ((src == `OSY_SRC_ACT_REF) && ref_rise) begin
        armed_q <= 1'b0;
      end else if ((src == `OSY_SRC_FEEDBACK) && fb_rollover) begin
        armed_q <= 1'b0;
      end
    end else if (prim_rise) begin
      armed_q <= 1'b1;
    end
  end

  assign direct_hit = (src == `OSY_SRC_DIRECT) && prim_fall;
  assign ref_hit    = (src == `OSY_SRC_ACT_REF) && ref_rise;
  assign fb_hit     = (src == `OSY_SRC_FEEDBACK) && fb_rollover;
  assign release_ev = direct_hit || (armed_q && (ref_hit || fb_hit));

  // ****************************************************************
  // Reclocking and restart
  // ****************************************************************
  // The release is held off a fixed number of clocks before the
  // dividers restart; the trigger synchronizer adds the rest.
  // Where a reference edge falls against the clock shifts the restart by
  // one clock; that uncertainty is inherent and is not corrected later.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rc_q      <= 3'h0;
      restart_q <= 1'b0;
    end else begin
      restart_q <= (rc_q == 3'h1);
      if (release_ev) begin
        rc_q <= `OSY_RECLOCK_CYCLES;
      end else if (rc_q != 3'h0) begin
        rc_q <= rc_q - 3'h1;
      end
    end
  end

  assign stall_int = armed_q | (rc_q != 3'h0);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= stall_int;
    end
  end

  // ****************************************************************
  // Channel dividers
  // ****************************************************************
  // The top byte of each ratio holds only six bits. A masked channel sees
  // neither stall nor restart, so its phase is left untouched.
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      wire [`OSY_DIV_WIDTH-1:0] ratio;
      assign ratio = {div_q[4*ch+3][5:0], div_q[4*ch+2], div_q[4*ch+1], div_q[4*ch]};
      osy_chan_div u_div (
        .clock    (clock),
        .rst_n    (rst_n),
        .ratio_m1 (ratio),
        .stall    (stall_int & ~mask[ch]),
        .restart  (restart_q & ~mask[ch]),
        .clk_out  (out_clk[ch])
      );
    end
  endgenerate

  // ****************************************************************
  // Closed-loop phase slew limiting
  // ****************************************************************
  // A zero limit applies the target at once; otherwise the applied
  // offset moves at most the limit per clock.
  // Stepping the offset too fast could make the loop lose lock; the limit
  // trades settling time for that safety.
  assign step_up = cl_tgt_q - phase_q;
  assign step_dn = phase_q - cl_tgt_q;

  always @* begin
    phase_d = cl_tgt_q;
    if (slew_q != 8'h00) begin
      if ((cl_tgt_q > phase_q) && (step_up > slew_q)) begin
        phase_d = phase_q + slew_q;
      end else if ((cl_tgt_q < phase_q) && (step_dn > slew_q)) begin
        phase_d = phase_q - slew_q;
      end
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 8'h00;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata     = rdata_q;
  assign sync_pending  = pend_q;
  assign phase_applied = phase_q;

endmodule // osy_output_sync

`default_nettype wire

// >>> bench/osy_output_sync_asserts.sv
// Purpose: Port checks for the output divider sync block.
// Assumes: Control bytes are shadowed from register writes.
// Notes:   Sees only the ports of osy_output_sync.
`timescale 1ns/100ps
`default_nettype none
`include "osy_defs.vh"
module osy_output_sync_asserts (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [7:0]  ref_in,
  input wire logic [2:0]  active_ref_sel,
  input wire logic        eeprom_sync_req,
  input wire logic        fb_rollover,
  input wire logic        sync_pending
);
  // ********
  // Shadow state
  // ********
  logic [5:0] ctrl_q;
  logic       sw_q;
  logic       pin_q;
  logic [3:0] quiet_q;
  wire        ctrl_wr = reg_wr && reg_addr == `OSY_ADDR_SYNC_CTRL;
  wire        sw_wr   = reg_wr && reg_addr == `OSY_ADDR_SW_SYNC;
  wire        calm    = !pin_q && !eeprom_sync_req && !sync_pending;
  wire [1:0]  mode    = ctrl_q[5:4];
  // Quiet counts cycles free of control writes and feedback pulses, so a
  // reclock count left over from an earlier mode has surely drained.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= 6'h00;
      sw_q    <= 1'b0;
      pin_q   <= 1'b0;
      quiet_q <= 4'h0;
    end else begin
      if (ctrl_wr)
        ctrl_q <= reg_wdata[5:0];
      if (sw_wr)
        sw_q <= reg_wdata[1];
      if (reg_wr && reg_addr == `OSY_ADDR_MF_SEL)
        pin_q <= reg_wdata[3];
      if (ctrl_wr || fb_rollover)
        quiet_q <= 4'h0;
      else if (quiet_q != 4'hf)
        quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_stall;
    sync_pending [*3];
  endsequence
  sequence s_release;
    ##[1:5] !sync_pending;
  endsequence
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");
  a_ctrl_readback: assert property (
    reg_rd && reg_addr == `OSY_ADDR_SYNC_CTRL |=> reg_rdata == {2'b00, $past(ctrl_q)})
    else $error("control read back wrong");
  a_direct_sync: assert property (
    sw_wr && !reg_wdata[1] && sw_q && mode == 2'h0 && calm && ctrl_q[3:0] != 4'hf
    |-> ##[1:4] s_stall ##0 s_release) else $error("direct sync timing wrong");
  a_arm_pending: assert property (
    sw_wr && reg_wdata[1] && !sw_q && ^mode && calm |-> ##[1:4] sync_pending)
    else $error("arming did not stall");
  a_ref_release: assert property (
    mode == 2'h1 && sync_pending && $rose(ref_in[active_ref_sel]) && $stable(active_ref_sel)
    |-> ##[3:12] !sync_pending) else $error("reference edge did not release");
  a_fb_hold: assert property (
    mode == 2'h2 && sync_pending && !fb_rollover && quiet_q > 4'h5 && !ctrl_wr
    |=> sync_pending) else $error("stall dropped without feedback edge");
  a_fb_release: assert property (
    mode == 2'h2 && sync_pending && fb_rollover && !ctrl_wr |-> ##[3:8] !sync_pending)
    else $error("feedback edge did not release");
  a_reserved_idle: assert property (
    mode == 2'h3 && quiet_q == 4'hf |-> !sync_pending) else $error("reserved mode synced");
endmodule // osy_output_sync_asserts
bind osy_output_sync osy_output_sync_asserts u_chk (.clock, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .ref_in, .active_ref_sel, .eeprom_sync_req, .fb_rollover,
  .sync_pending);
`default_nettype wire

// >>> bench/osy_far_side.sv
// Purpose: Far side model: input references and feedback edges.
// Assumes: References run free and unrelated to the clock.
// Notes:   A stopped reference holds low.
`timescale 1ns/100ps
`default_nettype none
module osy_far_side #(
  parameter int FB_PERIOD = 12
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] ref_run,
  input  wire logic       fb_run,
  output var  logic [7:0] ref_in,
  output var  logic       fb_rollover
);
  // ********
  // Sources
  // ********
  logic [7:0] cnt_q;
  for (genvar i = 0; i < 8; i++) begin : g_ref
    // Odd half periods make the edges wander against the clock.
    initial ref_in[i] = 1'b0;
    always #(71 + 30 * i) ref_in[i] = ref_run[i] ? ~ref_in[i] : 1'b0;
  end
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q       <= 8'h00;
      fb_rollover <= 1'b0;
    end else begin
      cnt_q       <= (cnt_q == 8'(FB_PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
      fb_rollover <= fb_run && cnt_q == 8'h00;
    end
  end
endmodule // osy_far_side
`default_nettype wire

// >>> bench/osy_output_sync_tb.sv
// Purpose: Self-checking bench for the output divider sync block.
// Assumes: 20 MHz clock; far side model supplies references.
// Notes:   Each scenario task judges its own results.
`timescale 1ns/100ps
`default_nettype none
module osy_output_sync_tb;
  // ********
  // Signals and instances
  // ********
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  multifunction_pins = 8'h00;
  logic [2:0]  active_ref_sel = 3'h0;
  logic        dpll_freq_lock = 1'b0;
  logic        dpll_phase_lock = 1'b0;
  logic        eeprom_sync_req = 1'b0;
  logic [7:0]  ref_run = 8'h00;
  logic        fb_run = 1'b0;
  wire  [7:0]  reg_rdata;
  wire  [7:0]  ref_in;
  wire         fb_rollover;
  wire  [3:0]  out_clk;
  wire         sync_pending;
  wire  [7:0]  phase_applied;
  int          bad_count = 0;
  int          cmp_count = 0;
  always #25 clock = ~clock;
  osy_output_sync DUT (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .multifunction_pins, .ref_in, .active_ref_sel, .dpll_freq_lock, .dpll_phase_lock,
    .eeprom_sync_req, .fb_rollover, .out_clk, .sync_pending, .phase_applied);
  osy_far_side u_far (.clock, .rst_n, .ref_run, .fb_run, .ref_in, .fb_rollover);
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
    tick;
  endtask
  task automatic wait_pend(input logic lv, input int k, input string n);
    for (int i = 0; i < k && sync_pending !== lv; i++)
      tick;
    chk(n, {7'h00, lv}, {7'h00, sync_pending});
  endtask
  task automatic expect_sync(input string n);
    wait_pend(1'b1, 12, n);
    wait_pend(1'b0, 30, n);
  endtask
  task automatic hold_low(input int k, input string n);
    logic s;
    s = 1'b0;
    repeat (k) begin
      tick;
      s = s | sync_pending;
    end
    chk(n, 8'h00, {7'h00, s});
  endtask
  task automatic per(input int c, input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    while (out_clk[c] !== 1'b1 && n < 8'h40) begin
      tick;
      n++;
    end
    n = 8'h00;
    do begin
      tick;
      n++;
    end while (out_clk[c] !== 1'b0 && n < 8'h40);
    while (out_clk[c] !== 1'b1 && n < 8'h40) begin
      tick;
      n++;
    end
    chk("period", e, n);
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    rd(16'h0402, 8'h00, "ctrl reset");
    wr(16'h0402, 8'hff);
    rd(16'h0402, 8'h3f, "ctrl rw");
    rd(16'h0555, 8'h00, "unmapped");
    for (int c = 0; c < 4; c++)
      wr(16'h0420 + 16'(4 * c), 8'(c + 1));
  endtask
  task automatic t_direct;
    wr(16'h0402, 8'h00);
    wr(16'h0a02, 8'h02);
    hold_low(6, "sw rise");
    wr(16'h0a02, 8'h00);
    expect_sync("sw fall");
    per(1, 8'h03);
    per(2, 8'h04);
  endtask
  task automatic t_sources;
    eeprom_sync_req <= 1'b1;
    tick;
    eeprom_sync_req <= 1'b0;
    expect_sync("eeprom");
    wr(16'h0410, 8'h0e);
    multifunction_pins <= 8'h40;
    hold_low(6, "pin rise");
    multifunction_pins <= 8'h00;
    expect_sync("pin fall");
    wr(16'h0410, 8'h00);
    wr(16'h0403, 8'h01);
    dpll_freq_lock <= 1'b1;
    expect_sync("freq lock");
    wr(16'h0403, 8'h02);
    tick;
    dpll_phase_lock <= 1'b1;
    expect_sync("phase lock");
    wr(16'h0403, 8'h00);
  endtask
  task automatic t_ref;
    logic [3:0] p;
    logic [3:0] x;
    ref_run        <= 8'h20;
    active_ref_sel <= 3'h2;
    wr(16'h0402, 8'h18);
    wr(16'h0a02, 8'h02);
    wait_pend(1'b1, 8, "armed");
    p = out_clk;
    x = 4'h0;
    repeat (20) begin
      tick;
      x = x | (out_clk ^ p);
      p = out_clk;
    end
    chk("stall", 8'h08, {4'h0, x});
    chk("idle ref", 8'h01, {7'h00, sync_pending});
    active_ref_sel <= 3'h5;
    wait_pend(1'b0, 30, "ref edge");
    hold_low(30, "one shot");
    wr(16'h0a02, 8'h00);
    hold_low(10, "no direct");
  endtask
  task automatic t_fb;
    ref_run <= 8'h00;
    fb_run  <= 1'b1;
    wr(16'h0402, 8'h20);
    wr(16'h0a02, 8'h02);
    expect_sync("feedback");
    wr(16'h0a02, 8'h00);
    hold_low(14, "fb once");
    fb_run <= 1'b0;
  endtask
  task automatic t_reserved;
    wr(16'h0402, 8'h30);
    wr(16'h0a02, 8'h02);
    wr(16'h0a02, 8'h00);
    hold_low(20, "reserved");
  endtask
  // Timing moves only after the syncs are done, in small steps; outputs
  // keep running, as disabling them meanwhile is optional.
  task automatic t_slew;
    wr(16'h0316, 8'h04);
    wr(16'h030f, 8'h10);
    for (int k = 1; k <= 4; k++) begin
      tick;
      chk("slew step", 8'(4 * k), phase_applied);
    end
    wr(16'h0316, 8'h00);
    wr(16'h030f, 8'h30);
    tick;
    chk("no limit", 8'h30, phase_applied);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    tick;
    t_regs;
    t_direct;
    t_sources;
    t_ref;
    t_fb;
    t_reserved;
    t_slew;
    tally_and_finish;
  end
  // The run needs well under 1000 cycles; 4000 leaves room for slow syncs.
  initial begin
    #200000;
    bad_count++;
    tally_and_finish;
  end
endmodule // osy_output_sync_tb
`default_nettype wire
